// File: src/stur_top.sv
// Purpose: Target-side readiness-test command handler with SCSI phases
// Assumes: Initiator REQ/ACK handshake on pins, APB for software
// Notes:   Status byte, then Command Complete, then bus free
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Six-byte CDB, opcode zero, LUN upper bits
// - Good only when nothing would be refused
// - Ignore element reservations of other initiators
// - Status phase sends exactly one byte
// - Message after status accepted, then bus free
// - Busy for other initiator or aborting motion
// - Unit reserved elsewhere gives reservation conflict
// - Message error with messages enabled: check
// - Parity error, messages disabled: check condition
// - Unimplemented LUN gives check condition
// - Pending unit attention gives check condition
// - Latched hardware error gives check condition
// - Any reserved CDB bit set: check condition
// - Manual or maintenance diagnostics: check condition
// - Command never starts a self-test
// - Hardware error sense key until reset; a write of the CTRL HWCLR bit also clears it once the COND STUR_C_HW_EVT bit is clear
// - Not ready sense, codes 04h and 89h
module stur_top (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        ack_n_i,
    output logic             req_o,
    output logic             cd_o,
    output logic             io_o,
    output logic             msg_o,
    output logic             bsy_o,
    output logic [7:0]       data_o,
    output logic             data_oe_o,
    output logic             busy_o,
    output logic             self_test_o
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_STAT, ST_STAT_ACK, ST_MSG, ST_MSG_ACK, ST_FREE
    } stur_state_t;

    stur_state_t          state_q;
    logic [31:0]          prdata_w;
    logic                 pslverr_w;
    logic                 pready_w;
    logic [63:0]          cdb_w;
    logic [stur_pkg::STUR_COND_W-1:0] cond_w;
    logic                 start_w;
    logic                 hwclr_w;
    logic                 ack_s1_q;
    logic                 ack_q;
    logic                 hw_err_q;
    logic [7:0]           status_w;
    stur_pkg::stur_sense_t sense_w;
    stur_pkg::stur_verdict_t verdict_q;
    stur_pkg::stur_sense_t sense_q;
    stur_pkg::stur_cdb_t  cdb_s;
    logic                 opcode_ok;

    assign cdb_s = stur_pkg::stur_cdb_t'(cdb_w[47:0]);

    // ------------------------------------------------------------------
    // Register file and decision
    // ------------------------------------------------------------------
    stur_apb u_apb (
        .clk_i         (clk_i),
        .sys_rst_i     (sys_rst_i),
        .psel_i        (psel_i),
        .penable_i     (penable_i),
        .pwrite_i      (pwrite_i),
        .paddr_i       (paddr_i),
        .pwdata_i      (pwdata_i),
        .status_word_i ({23'h0, verdict_q}),
        .sense_word_i  ({12'h000, sense_q}),
        .prdata_o      (prdata_w),
        .pready_o      (pready_w),
        .pslverr_o     (pslverr_w),
        .cdb_o         (cdb_w),
        .cond_o        (cond_w),
        .start_o       (start_w),
        .hwclr_o       (hwclr_w)
    );

    assign prdata_o  = prdata_w;
    assign pready_o  = pready_w;
    assign pslverr_o = pslverr_w;

    stur_decide u_decide (
        .hw_err_i (hw_err_q),
        .cdb_i    (cdb_s),
        .cond_i   (cond_w),
        .status_o (status_w),
        .sense_o  (sense_w)
    );

    assign opcode_ok = cdb_s.opcode == stur_pkg::STUR_OP_TUR;

    // ------------------------------------------------------------------
    // Acknowledge synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_s1_q <= 1'b0;
            ack_q    <= 1'b0;
        end else begin
            ack_s1_q <= ~ack_n_i;
            ack_q    <= ack_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Hardware error latch
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hw_err_q <= 1'b0;
        end else if (cond_w[stur_pkg::STUR_C_HW_EVT]) begin
            hw_err_q <= 1'b1;
        end else if (hwclr_w) begin
            hw_err_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Verdict capture
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            verdict_q <= '0;
            sense_q   <= '0;
        end else if (state_q == ST_IDLE && start_w && opcode_ok) begin
            verdict_q <= '{1'b1, status_w};
            sense_q   <= sense_w;
        end
    end

    // ------------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start_w && opcode_ok) state_q <= ST_STAT;
                end
                ST_STAT: begin
                    if (ack_q) state_q <= ST_STAT_ACK;
                end
                ST_STAT_ACK: begin
                    if (!ack_q) state_q <= ST_MSG;
                end
                ST_MSG: begin
                    if (ack_q) state_q <= ST_MSG_ACK;
                end
                ST_MSG_ACK: begin
                    if (!ack_q) state_q <= ST_FREE;
                end
                ST_FREE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Bus pins
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_o     <= 1'b0;
            cd_o      <= 1'b0;
            io_o      <= 1'b0;
            msg_o     <= 1'b0;
            bsy_o     <= 1'b0;
            data_o    <= 8'h00;
            data_oe_o <= 1'b0;
        end else begin
            req_o     <= (state_q == ST_STAT && !ack_q) ||
                         (state_q == ST_MSG && !ack_q);
            cd_o      <= state_q inside {ST_STAT, ST_STAT_ACK, ST_MSG,
                                         ST_MSG_ACK};
            io_o      <= state_q inside {ST_STAT, ST_STAT_ACK, ST_MSG,
                                         ST_MSG_ACK};
            msg_o     <= state_q inside {ST_MSG, ST_MSG_ACK};
            bsy_o     <= state_q inside {ST_STAT, ST_STAT_ACK, ST_MSG,
                                         ST_MSG_ACK};
            data_oe_o <= state_q inside {ST_STAT, ST_STAT_ACK, ST_MSG,
                                         ST_MSG_ACK};
            data_o    <= (state_q inside {ST_MSG, ST_MSG_ACK}) ?
                         stur_pkg::STUR_MSG_COMPLETE : verdict_q.status;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_o      <= 1'b0;
            self_test_o <= 1'b0;
        end else begin
            busy_o      <= state_q != ST_IDLE;
            self_test_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking chk_cb @(posedge clk_i);
    endclocking

    default disable iff (sys_rst_i);

    sequence stat_acked_s;
        (state_q == ST_STAT_ACK) ##1 !ack_q;
    endsequence

    one_status_a: assert property (
        $rose(req_o) && !msg_o |=>
        !$rose(req_o) until msg_o)
        else $error("second status request");

    msg_after_a: assert property (
        stat_acked_s |=>
        ##1 msg_o)
        else $error("message phase missing");

    busy_first_a: assert property (
        cond_w[stur_pkg::STUR_C_OTHER_CMD] |->
        status_w == stur_pkg::STUR_ST_BUSY)
        else $error("busy not chosen");

    resv_a: assert property (
        status_w == stur_pkg::STUR_ST_RESV |->
        cond_w[stur_pkg::STUR_C_RSV_OTHER])
        else $error("conflict without reservation");

    hw_check_a: assert property (
        hw_err_q && !busy_o |->
        status_w != stur_pkg::STUR_ST_GOOD)
        else $error("good despite hardware error");

    hw_sticky_a: assert property (
        hw_err_q && !hwclr_w |=>
        hw_err_q)
        else $error("hardware error lost");

    lun_check_a: assert property (
        cdb_s.lun != stur_pkg::STUR_LUN_MAX |->
        status_w != stur_pkg::STUR_ST_GOOD)
        else $error("good for bad lun");

    no_selftest_a: assert property (
        start_w |->
        ##[1:3] !self_test_o)
        else $error("self test started");

    free_after_a: assert property (
        state_q == ST_FREE |=>
        ##1 !bsy_o)
        else $error("bus not freed");

    pins_held_a: assert property (
        req_o |->
        cd_o && io_o && bsy_o && data_oe_o)
        else $error("request outside a phase");

    msg_byte_a: assert property (
        msg_o |->
        data_o == stur_pkg::STUR_MSG_COMPLETE)
        else $error("wrong message byte");

    status_byte_a: assert property (
        req_o && !msg_o |->
        data_o == verdict_q.status)
        else $error("wrong status byte");

    verdict_kept_a: assert property (
        start_w && opcode_ok && state_q == ST_IDLE |=>
        verdict_q.valid)
        else $error("verdict not captured");

    msg_err_a: assert property (
        cond_w[stur_pkg::STUR_C_MSG_EN] &&
        cond_w[stur_pkg::STUR_C_MSG_ERR] |->
        status_w != stur_pkg::STUR_ST_GOOD)
        else $error("good despite message error");

    parity_a: assert property (
        !cond_w[stur_pkg::STUR_C_MSG_EN] &&
        cond_w[stur_pkg::STUR_C_PAR_ERR] |->
        status_w != stur_pkg::STUR_ST_GOOD)
        else $error("good despite parity error");

    unit_attn_a: assert property (
        cond_w[stur_pkg::STUR_C_UNIT_ATTN] |->
        status_w != stur_pkg::STUR_ST_GOOD)
        else $error("good despite unit attention");

    rsvd_bits_a: assert property (
        cdb_s.rsvd1 != stur_pkg::STUR_B1_RSVD |->
        status_w != stur_pkg::STUR_ST_GOOD)
        else $error("good despite reserved bit");

    manual_a: assert property (
        cond_w[stur_pkg::STUR_C_MANUAL] ||
        cond_w[stur_pkg::STUR_C_DIAG] |->
        status_w != stur_pkg::STUR_ST_GOOD)
        else $error("good in manual mode");

    not_ready_a: assert property (
        status_w == stur_pkg::STUR_ST_CHECK &&
        sense_w.key == stur_pkg::STUR_SK_NOT_READY |->
        sense_w.asc == stur_pkg::STUR_ASC_NOT_READY &&
        sense_w.ascq == stur_pkg::STUR_ASCQ_MANUAL)
        else $error("wrong not ready codes");

    resv_last_a: assert property (
        status_w == stur_pkg::STUR_ST_RESV |->
        !hw_err_q && !cond_w[stur_pkg::STUR_C_UNIT_ATTN])
        else $error("conflict before check");

    conflict_a: assert property (
        cond_w[stur_pkg::STUR_C_RSV_OTHER] |->
        status_w != stur_pkg::STUR_ST_GOOD)
        else $error("good while reserved");

    idle_quiet_a: assert property (
        state_q == ST_IDLE && $past(state_q) == ST_IDLE |->
        !bsy_o && !req_o)
        else $error("bus held while idle");

endmodule : stur_top
`default_nettype wire

// File: src/stur_pkg.sv
// Purpose: Shared constants and types for the readiness-test handler
// Assumes: 32-bit APB register access, 200 MHz clock
// Notes:   Status, message and sense codes plus register layout
package stur_pkg;

    // ------------------------------------------------------------------
    // Command and status codes
    // ------------------------------------------------------------------
    localparam logic [7:0] STUR_OP_TUR        = 8'h00;
    localparam logic [7:0] STUR_ST_GOOD       = 8'h00;
    localparam logic [7:0] STUR_ST_CHECK      = 8'h02;
    localparam logic [7:0] STUR_ST_BUSY       = 8'h08;
    localparam logic [7:0] STUR_ST_RESV       = 8'h18;
    localparam logic [7:0] STUR_MSG_COMPLETE  = 8'h00;

    // ------------------------------------------------------------------
    // Sense data
    // ------------------------------------------------------------------
    localparam logic [3:0] STUR_SK_NONE       = 4'h0;
    localparam logic [3:0] STUR_SK_NOT_READY  = 4'h2;
    localparam logic [3:0] STUR_SK_HW_ERR     = 4'h4;
    localparam logic [3:0] STUR_SK_ILLEGAL    = 4'h5;
    localparam logic [3:0] STUR_SK_UNIT_ATTN  = 4'h6;
    localparam logic [3:0] STUR_SK_ABORTED    = 4'hB;
    localparam logic [7:0] STUR_ASC_NOT_READY = 8'h04;
    localparam logic [7:0] STUR_ASCQ_MANUAL   = 8'h89;
    localparam logic [7:0] STUR_ASC_INV_CDB   = 8'h24;
    localparam logic [7:0] STUR_ASC_INV_LUN   = 8'h25;
    localparam logic [7:0] STUR_ASC_ZERO      = 8'h00;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] STUR_REG_CDB_LO   = 12'h000;
    localparam logic [11:0] STUR_REG_CDB_HI   = 12'h004;
    localparam logic [11:0] STUR_REG_CTRL     = 12'h008;
    localparam logic [11:0] STUR_REG_COND     = 12'h00C;
    localparam logic [11:0] STUR_REG_RESULT   = 12'h010;
    localparam logic [11:0] STUR_REG_SENSE    = 12'h014;

    // CTRL bits
    localparam int STUR_CTRL_START   = 0;
    localparam int STUR_CTRL_HWCLR   = 1;
    // COND bits
    localparam int STUR_C_OTHER_CMD  = 0;
    localparam int STUR_C_ABORTING   = 1;
    localparam int STUR_C_RSV_OTHER  = 2;
    localparam int STUR_C_MSG_EN     = 3;
    localparam int STUR_C_MSG_ERR    = 4;
    localparam int STUR_C_PAR_ERR    = 5;
    localparam int STUR_C_UNIT_ATTN  = 6;
    localparam int STUR_C_MANUAL     = 7;
    localparam int STUR_C_DIAG       = 8;
    localparam int STUR_C_HW_EVT     = 9;
    localparam int STUR_COND_W       = 10;

    localparam logic [2:0] STUR_LUN_MAX  = 3'h0;
    localparam logic [4:0] STUR_B1_RSVD  = 5'h00;
    localparam logic [31:0] STUR_ZERO32  = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] rsvd4;
        logic [7:0] rsvd3;
        logic [7:0] rsvd2;
        logic [2:0] lun;
        logic [4:0] rsvd1;
        logic [7:0] opcode;
    } stur_cdb_t;

    typedef struct packed {
        logic [3:0] key;
        logic [7:0] asc;
        logic [7:0] ascq;
    } stur_sense_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] status;
    } stur_verdict_t;

endpackage : stur_pkg

// File: src/stur_decide.sv
// Purpose: Combinational status decision for the readiness test
// Assumes: Condition flags are stable while evaluated
// Notes:   One status byte and matching sense data
`timescale 1ns/1ps
`default_nettype none
module stur_decide (
    input  wire logic                       hw_err_i,
    input  wire stur_pkg::stur_cdb_t        cdb_i,
    input  wire logic [stur_pkg::STUR_COND_W-1:0] cond_i,
    output logic [7:0]                      status_o,
    output stur_pkg::stur_sense_t           sense_o
);

    logic busy;
    logic rsv;
    logic rsvd_set;
    logic bad_lun;
    logic not_rdy;

    always_comb begin
        busy     = cond_i[stur_pkg::STUR_C_OTHER_CMD] |
                   cond_i[stur_pkg::STUR_C_ABORTING];
        // Element reservations of others are not an input at all
        rsv      = cond_i[stur_pkg::STUR_C_RSV_OTHER];
        rsvd_set = (cdb_i.rsvd1 != stur_pkg::STUR_B1_RSVD) |
                   (|cdb_i.rsvd2) | (|cdb_i.rsvd3) | (|cdb_i.rsvd4);
        bad_lun  = cdb_i.lun > stur_pkg::STUR_LUN_MAX;
        not_rdy  = cond_i[stur_pkg::STUR_C_MANUAL] |
                   cond_i[stur_pkg::STUR_C_DIAG];
        sense_o  = '{stur_pkg::STUR_SK_NONE, stur_pkg::STUR_ASC_ZERO,
                     stur_pkg::STUR_ASC_ZERO};
        status_o = stur_pkg::STUR_ST_CHECK;
        if (busy) begin
            status_o = stur_pkg::STUR_ST_BUSY;
        end else if (cond_i[stur_pkg::STUR_C_MSG_EN] &
                     cond_i[stur_pkg::STUR_C_MSG_ERR]) begin
            sense_o.key = stur_pkg::STUR_SK_ABORTED;
        end else if (~cond_i[stur_pkg::STUR_C_MSG_EN] &
                     cond_i[stur_pkg::STUR_C_PAR_ERR]) begin
            sense_o.key = stur_pkg::STUR_SK_ABORTED;
        end else if (bad_lun) begin
            sense_o = '{stur_pkg::STUR_SK_ILLEGAL, stur_pkg::STUR_ASC_INV_LUN,
                        stur_pkg::STUR_ASC_ZERO};
        end else if (cond_i[stur_pkg::STUR_C_UNIT_ATTN]) begin
            sense_o.key = stur_pkg::STUR_SK_UNIT_ATTN;
        end else if (hw_err_i) begin
            sense_o.key = stur_pkg::STUR_SK_HW_ERR;
        end else if (rsvd_set) begin
            sense_o = '{stur_pkg::STUR_SK_ILLEGAL, stur_pkg::STUR_ASC_INV_CDB,
                        stur_pkg::STUR_ASC_ZERO};
        end else if (not_rdy) begin
            sense_o = '{stur_pkg::STUR_SK_NOT_READY,
                        stur_pkg::STUR_ASC_NOT_READY,
                        stur_pkg::STUR_ASCQ_MANUAL};
        end else if (rsv) begin
            status_o = stur_pkg::STUR_ST_RESV;
        end else begin
            status_o = stur_pkg::STUR_ST_GOOD;
        end
    end

endmodule : stur_decide
`default_nettype wire

// File: src/stur_apb.sv
// Purpose: APB slave register file for the readiness-test handler
// Assumes: One-wait-state APB, 32-bit aligned words
// Notes:   Unmapped addresses read zero and raise pslverr
`timescale 1ns/1ps
`default_nettype none
module stur_apb (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [31:0] status_word_i,
    input  wire logic [31:0] sense_word_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic [63:0]      cdb_o,
    output logic [stur_pkg::STUR_COND_W-1:0] cond_o,
    output logic             start_o,
    output logic             hwclr_o
);

    logic acc;
    logic wr;
    logic mapped;

    assign acc = psel_i & penable_i;
    assign wr  = acc & pready_o & pwrite_i;

    always_comb begin
        unique case (paddr_i)
            stur_pkg::STUR_REG_CDB_LO, stur_pkg::STUR_REG_CDB_HI,
            stur_pkg::STUR_REG_CTRL, stur_pkg::STUR_REG_COND,
            stur_pkg::STUR_REG_RESULT, stur_pkg::STUR_REG_SENSE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // One wait state keeps every answer registered
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= acc & ~pready_o;
            pslverr_o <= acc & ~pready_o & ~mapped;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cdb_o  <= '0;
            cond_o <= '0;
        end else if (wr) begin
            if (paddr_i == stur_pkg::STUR_REG_CDB_LO) cdb_o[31:0] <= pwdata_i;
            if (paddr_i == stur_pkg::STUR_REG_CDB_HI) cdb_o[63:32] <= pwdata_i;
            if (paddr_i == stur_pkg::STUR_REG_COND)
                cond_o <= pwdata_i[stur_pkg::STUR_COND_W-1:0];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            start_o <= 1'b0;
            hwclr_o <= 1'b0;
        end else begin
            start_o <= wr & (paddr_i == stur_pkg::STUR_REG_CTRL) &
                       pwdata_i[stur_pkg::STUR_CTRL_START];
            hwclr_o <= wr & (paddr_i == stur_pkg::STUR_REG_CTRL) &
                       pwdata_i[stur_pkg::STUR_CTRL_HWCLR];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_o <= stur_pkg::STUR_ZERO32;
        end else if (acc & ~pready_o & ~pwrite_i) begin
            unique case (paddr_i)
                stur_pkg::STUR_REG_CDB_LO: prdata_o <= cdb_o[31:0];
                stur_pkg::STUR_REG_CDB_HI: prdata_o <= cdb_o[63:32];
                stur_pkg::STUR_REG_COND:   prdata_o <= {22'h0, cond_o};
                stur_pkg::STUR_REG_RESULT: prdata_o <= status_word_i;
                stur_pkg::STUR_REG_SENSE:  prdata_o <= sense_word_i;
                default:                   prdata_o <= stur_pkg::STUR_ZERO32;
            endcase
        end else begin
            prdata_o <= stur_pkg::STUR_ZERO32;
        end
    end

endmodule : stur_apb
`default_nettype wire

// File: test/stur_init_model.sv
// Purpose: Initiator side of the REQ/ACK handshake
// Assumes: Target raises req_i with data_i valid
// Notes:   Ack delay set by delay_i; counts bytes taken
`timescale 1ns/1ps
`default_nettype none
module stur_init_model (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       req_i,
    input  wire logic       msg_i,
    input  wire logic [7:0] data_i,
    input  wire logic [3:0] delay_i,
    output logic            ack_n_o,
    output logic [7:0]      status_byte_o,
    output logic [7:0]      msg_byte_o,
    output logic [7:0]      n_bytes_o
);
    logic [3:0] cnt_q;
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_n_o   <= 1'b1;
            cnt_q     <= 4'h0;
            n_bytes_o <= 8'h00;
        end else if (ack_n_o && req_i) begin
            if (cnt_q >= delay_i) begin
                ack_n_o   <= 1'b0;
                cnt_q     <= 4'h0;
                n_bytes_o <= n_bytes_o + 8'h01;
                if (msg_i) msg_byte_o <= data_i;
                else status_byte_o <= data_i;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end else if (!ack_n_o && !req_i) begin
            ack_n_o <= 1'b1;
        end
    end
endmodule : stur_init_model
`default_nettype wire

// File: test/tb_top.sv
// Purpose: Self-checking bench of the readiness-test handler
// Assumes: APB slave may wait, LUN 0 only
// Notes:   Integer model predicts status and sense
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    logic        clk_i = 0, sys_rst_i = 1;
    logic        psel = 0, penable = 0, pwrite = 0, ack_n, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        req, cd, io, msg, bsy, oe, busy, self_test;
    logic [7:0]  data, st_b, msg_b, nb;
    logic [3:0]  dly = 4'h0;
    int          n_fail = 0, samples_checked = 0, hw_q = 0;
    always #2.5 clk_i = ~clk_i;
    stur_top stur_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .ack_n_i(ack_n), .req_o(req), .cd_o(cd),
        .io_o(io), .msg_o(msg), .bsy_o(bsy), .data_o(data),
        .data_oe_o(oe), .busy_o(busy), .self_test_o(self_test));
    stur_init_model stur_init_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .req_i(req), .msg_i(msg), .data_i(data), .delay_i(dly),
        .ack_n_o(ack_n), .status_byte_o(st_b), .msg_byte_o(msg_b),
        .n_bytes_o(nb));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge clk_i); k++; end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        if (k >= 50) begin n_fail++; stop_test(); end
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk_i);
    endtask : apb
    // Model: {status, key, asc, ascq}
    function automatic logic [27:0] pred(logic [9:0] c, logic [47:0] b);
        if (c[0] | c[1]) return {8'h08, 20'h0};
        if (c[3] & c[4]) return {8'h02, 4'hB, 16'h0};
        if (c[5] & !c[3]) return {8'h02, 4'hB, 16'h0};
        if (b[15:13] != 0) return {8'h02, 4'h5, 16'h2500};
        if (c[6]) return {8'h02, 4'h6, 16'h0};
        if (hw_q != 0) return {8'h02, 4'h4, 16'h0};
        if (b[12:8] != 0 || b[39:16] != 0)
            return {8'h02, 4'h5, 16'h2400};
        if (c[7] | c[8]) return {8'h02, 4'h2, 16'h0489};
        if (c[2]) return {8'h18, 20'h0};
        return {8'h00, 20'h0};
    endfunction : pred
    task automatic run(input int id, input logic [9:0] c,
                       input logic [47:0] b);
        logic [27:0] e;
        logic [7:0]  n0;
        int          k;
        apb(1'b1, 12'h000, b[31:0]);
        apb(1'b1, 12'h004, {16'h0000, b[47:32]});
        apb(1'b1, 12'h00C, {22'h0, c});
        if (c[9]) hw_q = 1;
        e = pred(c, b);
        n0 = nb;
        apb(1'b1, 12'h008, 32'h0000_0001);
        k = 0;
        repeat (3) @(posedge clk_i);
        while ((busy | bsy) !== 1'b0 && k < 400) begin
            @(posedge clk_i); k++;
        end
        if (k >= 400) begin n_fail++; stop_test(); end
        if (b[7:0] != 0) begin
            `CHK(nb, n0)
        end else begin
            `CHK(nb, n0 + 8'h02)
            `CHK(st_b, e[27:20])
            `CHK(msg_b, 8'h00)
            apb(1'b0, 12'h010, 32'h0);
            `CHK(rd, {23'h0, 1'b1, e[27:20]})
            apb(1'b0, 12'h014, 32'h0);
            if (e[19:16] == 4'h2 || e[19:16] == 4'h5) begin
                `CHK(rd[19:0], e[19:0])
            end else if (e[27:20] == 8'h02) begin
                `CHK(rd[19:16], e[19:16])
            end
        end
        `CHK({bsy, req, cd, io, msg, oe, self_test}, 7'h00)
        $display("test %0d done", id);
    endtask : run
    initial begin
        logic [47:0] b;
        void'($urandom(32'h2f72));
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        apb(1'b0, 12'h020, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        run(1, 10'h000, 48'h0);
        run(2, 10'h000, 48'h0000_0000_0003);
        for (int i = 0; i < 10; i++) begin
            dly <= 4'(i);
            run(10 + i, 10'(1 << i), 48'h0);
        end
        run(20, 10'h000, 48'h0);
        apb(1'b1, 12'h008, 32'h0000_0002);
        hw_q = 0;
        run(21, 10'h000, 48'h0000_0000_2000);
        run(22, 10'h000, 48'h0000_0000_0100);
        run(23, 10'h000, 48'h0000_0100_0000);
        for (int i = 0; i < 40; i++) begin
            dly <= 4'($urandom_range(0, 5));
            b = {16'($urandom), 32'h0};
            if ($urandom_range(0, 7) == 0) b[39:8] = 32'($urandom);
            run(30 + i, 10'($urandom & $urandom & $urandom) & 10'h1FF, b);
        end
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
